// *** rtl/bitops_pkg.sv ***
// Purpose: Shared constants and types for the bit, shift and flag datapath
// Assumes: 8-bit data, 8-bit status register, 6-bit I/O address space
// Notes:   Operation codes are arbitrary encodings of this block
package bitops_pkg;

    // ========================================================================
    // Widths
    // ========================================================================
    localparam int DATA_W   = 8;
    localparam int REG_AW   = 5;
    localparam int IO_AW    = 6;

    // ========================================================================
    // Status register bit positions
    // ========================================================================
    localparam int FLAG_C   = 0;
    localparam int FLAG_Z   = 1;
    localparam int FLAG_N   = 2;
    localparam int FLAG_V   = 3;
    localparam int FLAG_S   = 4;
    localparam int FLAG_H   = 5;
    localparam int FLAG_T   = 6;
    localparam int FLAG_I   = 7;

    // ========================================================================
    // Reset values and cycle counts
    // ========================================================================
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET   = 8'h00;
    localparam int         CYC_SINGLE   = 1;
    localparam int         CYC_IO_BIT   = 2;

    // ========================================================================
    // Operations
    // ========================================================================
    typedef enum logic [3:0] {
        OP_NONE,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_ARITH_SHIFT_RIGHT,
        OP_NIBBLE_SWAP,
        OP_LOGIC_SHIFT_LEFT,
        OP_LOGIC_SHIFT_RIGHT,
        OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR,
        OP_BIT_TO_TRANSFER,
        OP_TRANSFER_TO_BIT,
        OP_FLAG_INDEX_SET,
        OP_FLAG_INDEX_CLEAR
    } op_type;

    typedef enum {
        IO_IDLE,
        IO_WRITE
    } io_state_type;

endpackage : bitops_pkg

// *** rtl/shift_unit.sv ***
// Purpose: Combinational shift, rotate and swap result with flag outcome
// Assumes: Caller registers the result; op is one of the shift group
// Notes:   Overflow is N xor C after the shift, sign is N xor V
`timescale 1ns/1ns
module shift_unit (
    // Operation and operand
    input  wire bitops_pkg::op_type op,
    input  wire logic [7:0]         operand,
    input  wire logic               carry_in,
    // Result
    output logic [7:0]              result,
    output logic                    carry_out,
    output logic                    zero_out,
    output logic                    neg_out,
    output logic                    ovf_out,
    output logic                    sign_out
);
    import bitops_pkg::*;

    // ========================================================================
    // Result selection
    // ========================================================================
    always_comb begin
        result    = operand;
        carry_out = carry_in;
        case (op)
            OP_ROTATE_LEFT_CARRY: begin
                result    = {operand[6:0], carry_in};
                carry_out = operand[7];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                result    = {carry_in, operand[7:1]};
                carry_out = operand[0];
            end
            OP_ARITH_SHIFT_RIGHT: begin
                result    = {operand[7], operand[7:1]};
                carry_out = operand[0];
            end
            OP_NIBBLE_SWAP: begin
                result    = {operand[3:0], operand[7:4]};
            end
            OP_LOGIC_SHIFT_LEFT: begin
                result    = {operand[6:0], 1'b0};
                carry_out = operand[7];
            end
            OP_LOGIC_SHIFT_RIGHT: begin
                result    = {1'b0, operand[7:1]};
                carry_out = operand[0];
            end
            default: begin
                result    = operand;
                carry_out = carry_in;
            end
        endcase
    end

    // Flags derived from the shifted value
    always_comb begin
        zero_out = (result == 8'h00);
        neg_out  = result[7];
        ovf_out  = result[7] ^ carry_out;
        sign_out = neg_out ^ ovf_out;
    end

endmodule : shift_unit

// *** rtl/bit_shift_flag_ops.sv ***
// Purpose: Shift, rotate, swap, bit transfer, I/O bit and flag operations
// Assumes: One op request per cycle when ready; operands valid with op_valid
// Notes:   I/O bit ops are read-modify-write over two clocks
//          Requests made while op_ready is low are dropped, not queued
//          Flag index 7 is the interrupt enable; nothing here guards it
// Operation
// - Rotate left through carry, flags, one clock
// - Rotate right through carry, flags, one clock
// - Arithmetic right shift keeps bit seven
// - Swap nibbles, flags unchanged, one clock
// - Logical left shift, zero into bit0
// - Logical right shift, zero into bit7
// - I/O bit set/clear, two clocks
// - Copy register bit into transfer flag
// - Copy transfer flag into register bit
// - Half-carry set and clear, flag index 5
// - Overflow set and clear, flag index 3; the other six flags by their own indices
`timescale 1ns/1ns
module bit_shift_flag_ops (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Operation request
    input  wire logic               op_valid,
    input  wire bitops_pkg::op_type op,
    input  wire logic [4:0]         reg_addr,
    input  wire logic [7:0]         reg_data,
    input  wire logic [2:0]         bit_index,
    input  wire logic [5:0]         io_addr,
    // I/O space read data for the addressed register
    input  wire logic [7:0]         io_rdata,
    // Working register writeback
    output logic                    reg_we,
    output logic [4:0]              reg_waddr,
    output logic [7:0]              reg_wdata,
    // I/O space access
    output logic                    io_re,
    output logic                    io_we,
    output logic [5:0]              io_waddr,
    output logic [7:0]              io_wdata,
    // Status and handshake
    output logic [7:0]              status_register,
    output logic                    op_ready,
    output logic                    op_done
);
    import bitops_pkg::*;

    // ========================================================================
    // Declarations
    // ========================================================================
    // Registered outputs
    logic [7:0]   status_ff;
    logic         reg_we_ff;
    logic [4:0]   reg_waddr_ff;
    logic [7:0]   reg_wdata_ff;
    logic         io_re_ff;
    logic         io_we_ff;
    logic [5:0]   io_addr_ff;
    logic [7:0]   io_wdata_ff;
    logic         done_ff;
    logic         ready_ff;

    // I/O read-modify-write context, held across the two clocks
    io_state_type io_state_ff;
    logic [2:0]   io_bit_ff;
    logic         io_set_ff;

    // Combinational results of the shift unit
    logic [7:0]   sh_result;
    logic         sh_carry;
    logic         sh_zero;
    logic         sh_neg;
    logic         sh_ovf;
    logic         sh_sign;

    // Request decode
    logic         accept;
    logic         is_shift;

    // One-hot mask of a bit index
    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction : bit_mask

    // Byte with one bit forced to the given level, all others kept
    function automatic logic [7:0] bit_write(input logic [7:0] value,
                                             input logic [2:0] idx,
                                             input logic       level);
        bit_write = level ? (value | bit_mask(idx)) : (value & ~bit_mask(idx));
    endfunction : bit_write

    // The two I/O bit operations share the read-modify-write path
    function automatic logic io_bit_op(input op_type code);
        io_bit_op = (code == OP_IO_BIT_SET) || (code == OP_IO_BIT_CLEAR);
    endfunction : io_bit_op

    // ========================================================================
    // Shift datapath
    // ========================================================================
    // The unit sees the operand and the live carry every clock; its outputs
    // only matter in a clock that accepts a shift-group or swap request
    shift_unit u_shift (
        .op        (op),
        .operand   (reg_data),
        .carry_in  (status_ff[FLAG_C]),
        .result    (sh_result),
        .carry_out (sh_carry),
        .zero_out  (sh_zero),
        .neg_out   (sh_neg),
        .ovf_out   (sh_ovf),
        .sign_out  (sh_sign)
    );

    // ========================================================================
    // Request decode
    // ========================================================================
    // Requests are refused while the I/O write cycle is in progress
    assign accept   = op_valid && (io_state_ff == IO_IDLE);
    assign is_shift = (op == OP_ROTATE_LEFT_CARRY) || (op == OP_ROTATE_RIGHT_CARRY) ||
                      (op == OP_ARITH_SHIFT_RIGHT) || (op == OP_LOGIC_SHIFT_LEFT) ||
                      (op == OP_LOGIC_SHIFT_RIGHT);

    // ========================================================================
    // Status register
    // ========================================================================
    // Swap, I/O bit ops and the bit load leave every flag alone
    // Layout from bit 0 upward: C, Z, N, V, S, H, T, I
    // One request per clock, so no two branches compete for a flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= STATUS_RESET;
        end else if (accept) begin
            case (op)
                OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT,
                OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT: begin
                    // H, T and I hold; V is N xor C, S is N xor V
                    status_ff[FLAG_C] <= sh_carry;
                    status_ff[FLAG_Z] <= sh_zero;
                    status_ff[FLAG_N] <= sh_neg;
                    status_ff[FLAG_V] <= sh_ovf;
                    status_ff[FLAG_S] <= sh_sign;
                end
                OP_BIT_TO_TRANSFER: begin
                    // Only T moves; the source register is not written back
                    status_ff[FLAG_T] <= reg_data[bit_index];
                end
                OP_FLAG_INDEX_SET: begin
                    // Half-carry and overflow set are the index 5 and 3 forms
                    // Index 0 to 7 maps straight onto the layout above
                    status_ff <= status_ff | bit_mask(bit_index);
                end
                OP_FLAG_INDEX_CLEAR: begin
                    status_ff <= status_ff & ~bit_mask(bit_index);
                end
                default: begin
                    // Swap, bit load, I/O ops and the no-op keep every flag
                    status_ff <= status_ff;
                end
            endcase
        end
    end

    // ========================================================================
    // Working register writeback
    // ========================================================================
    // The operand arrives as data, so the register file read stays outside;
    // this block only returns the new value and where it belongs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_we_ff    <= 1'b0;
            reg_waddr_ff <= 5'h00;
            reg_wdata_ff <= DATA_RESET;
        end else begin
            reg_we_ff <= 1'b0;
            // Shift group and swap return the unit's result
            if (accept && (is_shift || op == OP_NIBBLE_SWAP)) begin
                reg_we_ff    <= 1'b1;
                reg_waddr_ff <= reg_addr;
                reg_wdata_ff <= sh_result;
            end else if (accept && op == OP_TRANSFER_TO_BIT) begin
                reg_we_ff    <= 1'b1;
                reg_waddr_ff <= reg_addr;
                reg_wdata_ff <= bit_write(reg_data, bit_index, status_ff[FLAG_T]);
            end
        end
    end

    // ========================================================================
    // I/O bit set and clear: read in the first clock, write in the second
    // ========================================================================
    // The read strobe goes out registered; io_rdata is taken in IO_WRITE
    // Clock after the request: address and read strobe out, byte comes back
    // Next edge: byte sampled, modified and sent with the write strobe
    // Nothing is taken in between, so the byte cannot go stale here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_state_ff <= IO_IDLE;
            io_re_ff    <= 1'b0;
            io_we_ff    <= 1'b0;
            io_addr_ff  <= 6'h00;
            io_wdata_ff <= DATA_RESET;
            io_bit_ff   <= 3'h0;
            io_set_ff   <= 1'b0;
        end else begin
            io_re_ff <= 1'b0;
            io_we_ff <= 1'b0;
            case (io_state_ff)
                IO_IDLE: begin
                    if (accept && io_bit_op(op)) begin
                        io_state_ff <= IO_WRITE;
                        io_re_ff    <= 1'b1;
                        io_addr_ff  <= io_addr;
                        io_bit_ff   <= bit_index;
                        io_set_ff   <= (op == OP_IO_BIT_SET);
                    end
                end
                IO_WRITE: begin
                    io_state_ff <= IO_IDLE;
                    io_we_ff    <= 1'b1;
                    io_wdata_ff <= bit_write(io_rdata, io_bit_ff, io_set_ff);
                end
                default: begin
                    io_state_ff <= IO_IDLE;
                end
            endcase
        end
    end

    // ========================================================================
    // Completion pulse
    // ========================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_ff <= 1'b0;
        end else if (io_state_ff == IO_WRITE) begin
            done_ff <= 1'b1;
        end else if (accept && !io_bit_op(op) && op != OP_NONE) begin
            // The no-op is taken but raises no pulse, so idling with valid high is harmless
            done_ff <= 1'b1;
        end else begin
            done_ff <= 1'b0;
        end
    end

    // ========================================================================
    // Request acceptance
    // ========================================================================
    // A flop of its own so op_ready leaves straight from a register; it is low
    // for exactly the clock in which the I/O write is pending
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_ff <= 1'b1;
        end else if (io_state_ff == IO_WRITE) begin
            ready_ff <= 1'b1;
        end else if (accept && io_bit_op(op)) begin
            ready_ff <= 1'b0;
        end
    end

    // Outputs straight from flip-flops
    assign status_register = status_ff;
    assign reg_we          = reg_we_ff;
    assign reg_waddr       = reg_waddr_ff;
    assign reg_wdata       = reg_wdata_ff;
    assign io_re           = io_re_ff;
    assign io_we           = io_we_ff;
    assign io_waddr        = io_addr_ff;
    assign io_wdata        = io_wdata_ff;
    assign op_done         = done_ff;
    assign op_ready        = ready_ff;

endmodule : bit_shift_flag_ops

// *** verification/bit_shift_flag_ops_sva.sv ***
// Purpose: Concurrent checks on the bit, shift and flag datapath ports
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Sees only the top module ports; bound after the module
`timescale 1ns/1ns
module bit_shift_flag_ops_sva
    import bitops_pkg::*;
(
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    // Request
    input wire logic               op_valid,
    input wire bitops_pkg::op_type op,
    input wire logic [4:0]         reg_addr,
    input wire logic [7:0]         reg_data,
    input wire logic [2:0]         bit_index,
    input wire logic [5:0]         io_addr,
    input wire logic [7:0]         io_rdata,
    // Results
    input wire logic               reg_we,
    input wire logic [4:0]         reg_waddr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               io_re,
    input wire logic               io_we,
    input wire logic [5:0]         io_waddr,
    input wire logic [7:0]         io_wdata,
    input wire logic [7:0]         status_register,
    input wire logic               op_ready,
    input wire logic               op_done
);
    // ========================================
    // Request taken on this edge
    // ========================================
    logic take;
    assign take = op_valid && op_ready;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ========================================
    // Shift group and swap: rotates take the old carry into the result
    // ========================================
    a_rol_result:
    assert property (take && op == OP_ROTATE_LEFT_CARRY |=> reg_we && op_done
        && reg_wdata == {$past(reg_data[6:0]), $past(status_register[FLAG_C])}
        && status_register[FLAG_C] == $past(reg_data[7])) else $error("rotate left wrong");
    a_ror_result:
    assert property (take && op == OP_ROTATE_RIGHT_CARRY |=> reg_we && op_done
        && reg_wdata == {$past(status_register[FLAG_C]), $past(reg_data[7:1])}
        && status_register[FLAG_C] == $past(reg_data[0])) else $error("rotate right wrong");
    a_asr_result:
    assert property (take && op == OP_ARITH_SHIFT_RIGHT |=> reg_we
        && reg_wdata == {$past(reg_data[7]), $past(reg_data[7:1])}) else $error("asr wrong");
    a_swap_keeps_flags:
    assert property (take && op == OP_NIBBLE_SWAP |=> reg_we && $stable(status_register)
        && reg_wdata == {$past(reg_data[3:0]), $past(reg_data[7:4])}) else $error("swap wrong");
    a_lsl_result:
    assert property (take && op == OP_LOGIC_SHIFT_LEFT |=> reg_we
        && reg_wdata == {$past(reg_data[6:0]), 1'b0}) else $error("lsl wrong");
    a_lsr_result:
    assert property (take && op == OP_LOGIC_SHIFT_RIGHT |=> reg_we
        && reg_wdata == {1'b0, $past(reg_data[7:1])}) else $error("lsr wrong");

    // ========================================
    // I/O bit access: read, then write a cycle later
    // ========================================
    a_io_two_clocks:
    assert property (take && (op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR)
        |=> io_re && !op_ready ##1 io_we && op_done && !io_re) else $error("io timing wrong");
    a_io_set_bit:
    assert property (take && op == OP_IO_BIT_SET ##1 1'b1 |=> $stable(status_register)
        && io_wdata == ($past(io_rdata) | (8'h01 << $past(bit_index, 2))))
        else $error("io set wrong");
    a_blocked_ignored:
    assert property (op_valid && !op_ready |=> !reg_we && !io_re) else $error("blocked taken");

    // ========================================
    // Transfer bit and flag index operations
    // ========================================
    a_bit_store:
    assert property (take && op == OP_BIT_TO_TRANSFER
        |=> status_register[FLAG_T] == $past(reg_data[bit_index])) else $error("store wrong");
    a_bit_load:
    assert property (take && op == OP_TRANSFER_TO_BIT |=> reg_we && $stable(status_register)
        && reg_wdata[$past(bit_index)] == $past(status_register[FLAG_T]))
        else $error("load wrong");
    a_flag_set_one:
    assert property (take && op == OP_FLAG_INDEX_SET |=> op_done
        && status_register == ($past(status_register) | (8'h01 << $past(bit_index))))
        else $error("flag set wrong");
    a_flag_clear_one:
    assert property (take && op == OP_FLAG_INDEX_CLEAR
        |=> status_register == ($past(status_register) & ~(8'h01 << $past(bit_index))))
        else $error("flag clear wrong");
endmodule : bit_shift_flag_ops_sva

bind bit_shift_flag_ops bit_shift_flag_ops_sva i_sva (
    .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op(op), .reg_addr(reg_addr),
    .reg_data(reg_data), .bit_index(bit_index), .io_addr(io_addr), .io_rdata(io_rdata),
    .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .io_re(io_re),
    .io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata),
    .status_register(status_register), .op_ready(op_ready), .op_done(op_done)
);

// *** verification/test_bit_shift_flag_ops.sv ***
// Purpose: Self-checking bench for the bit, shift and flag datapath
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Reference model keeps its own copy of the status flags
`timescale 1ns/1ns
module test_bit_shift_flag_ops
    import bitops_pkg::*;
;
    // ========================================
    // Stimulus and observed signals
    // ========================================
    logic       clk = 1'b0;
    logic       rst_n, op_valid, reg_we, io_re, io_we, op_ready, op_done;
    op_type     op;
    logic [4:0] reg_addr, reg_waddr;
    logic [7:0] reg_data, io_rdata, reg_wdata, io_wdata, status_register, st_model;
    logic [2:0] bit_index;
    logic [5:0] io_addr, io_waddr;
    int         n_mismatch, total_checks, rnd_state;

    bit_shift_flag_ops i_dut (
        .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op(op), .reg_addr(reg_addr),
        .reg_data(reg_data), .bit_index(bit_index), .io_addr(io_addr), .io_rdata(io_rdata),
        .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .io_re(io_re),
        .io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata),
        .status_register(status_register), .op_ready(op_ready), .op_done(op_done)
    );

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    // ========================================
    // Helpers
    // ========================================
    function automatic logic [7:0] rnd8();
        rnd_state = rnd_state ^ (rnd_state << 13);
        rnd_state = rnd_state ^ (rnd_state >> 17);
        rnd_state = rnd_state ^ (rnd_state << 5);
        return rnd_state[7:0];
    endfunction : rnd8

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Present a request and let the taking edge pass
    task automatic issue(input op_type o, input logic [7:0] d, input logic [2:0] b);
        op_valid = 1'b1;
        op = o;
        reg_data = d;
        bit_index = b;
        reg_addr = 5'(rnd8());
        io_addr = 6'(rnd8());
        @(posedge clk);
        #1;
    endtask : issue

    // Single-clock op against the model; back to back, so valid is never dropped here
    task automatic run_op(input op_type o, input logic [7:0] d, input logic [2:0] b);
        logic [7:0] r;
        logic [7:0] s;
        logic       c;
        s = st_model;
        r = d;
        c = s[FLAG_C];
        case (o)
            OP_ROTATE_LEFT_CARRY:  {c, r} = {d, s[FLAG_C]};
            OP_ROTATE_RIGHT_CARRY: {r, c} = {s[FLAG_C], d};
            OP_ARITH_SHIFT_RIGHT:  {r, c} = {d[7], d};
            OP_LOGIC_SHIFT_LEFT:   {c, r} = {d, 1'b0};
            OP_LOGIC_SHIFT_RIGHT:  {r, c} = {1'b0, d};
            OP_NIBBLE_SWAP:        r = {d[3:0], d[7:4]};
            OP_TRANSFER_TO_BIT:    r[b] = s[FLAG_T];
            OP_BIT_TO_TRANSFER:    s[FLAG_T] = d[b];
            OP_FLAG_INDEX_SET:     s[b] = 1'b1;
            default:               s[b] = 1'b0;
        endcase
        if (o inside {[OP_ROTATE_LEFT_CARRY:OP_ARITH_SHIFT_RIGHT], OP_LOGIC_SHIFT_LEFT,
                      OP_LOGIC_SHIFT_RIGHT}) begin
            s[FLAG_C] = c;
            s[FLAG_Z] = (r == 8'h00);
            s[FLAG_N] = r[7];
            s[FLAG_V] = r[7] ^ c;
            s[FLAG_S] = r[7] ^ s[FLAG_V];
        end
        issue(o, d, b);
        chk(status_register, s);
        chk({4'h0, io_we, io_re, op_ready, op_done}, 8'h03);
        if (o inside {[OP_ROTATE_LEFT_CARRY:OP_LOGIC_SHIFT_RIGHT], OP_TRANSFER_TO_BIT}) begin
            chk(reg_wdata, r);
            chk({reg_we, 2'b00, reg_waddr}, {3'b100, reg_addr});
        end else begin
            chk({7'h00, reg_we}, 8'h00);
        end
        st_model = s;
    endtask : run_op

    // Two-clock I/O bit op; a flag request in the blocked cycle must leave no trace
    task automatic run_io(input op_type o, input logic [2:0] b);
        logic [7:0] v;
        v = rnd8();
        issue(o, rnd8(), b);
        chk({io_re, op_ready, io_waddr}, {2'b10, io_addr});
        io_rdata = v;
        op = (b[0]) ? OP_FLAG_INDEX_SET : OP_FLAG_INDEX_CLEAR;
        bit_index = ~b;
        @(posedge clk);
        #1;
        chk({3'h0, io_we, op_done, reg_we, io_re, op_ready}, 8'h19);
        chk(io_wdata, (o == OP_IO_BIT_SET) ? v | (8'h01 << b) : v & ~(8'h01 << b));
        chk(status_register, st_model);
    endtask : run_io

    task automatic print_verdict();
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // ========================================
    // Main sequence
    // ========================================
    initial begin
        {rst_n, op_valid, reg_addr, reg_data, bit_index, io_addr, io_rdata} = '0;
        op = OP_NONE;
        st_model = STATUS_RESET;
        rnd_state = 12;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        // Boundary operands first, then random ones, for every shift and the swap
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 8; i++) begin
                run_op(op_type'(k + 1), (i == 0) ? 8'h00 : (i == 1) ? 8'h81 : rnd8(), 3'(i));
            end
        end
        for (int b = 0; b < 8; b++) begin
            run_op(OP_BIT_TO_TRANSFER, rnd8(), 3'(b));
            run_op(OP_TRANSFER_TO_BIT, rnd8(), 3'(7 - b));
            run_io(OP_IO_BIT_SET, 3'(b));
            run_io(OP_IO_BIT_CLEAR, 3'(b));
            run_op(OP_FLAG_INDEX_SET, rnd8(), 3'(b));
            run_op(OP_FLAG_INDEX_CLEAR, rnd8(), 3'(b ^ 1));
        end
        op_valid = 1'b0;
        print_verdict();
    end

    // Watchdog far beyond the roughly 120 cycles the sequence needs
    initial begin
        #50000;
        n_mismatch++;
        print_verdict();
    end
endmodule : test_bit_shift_flag_ops
